// *** verilog/irq_enable_pkg.sv ***
// Constants and types for the device interrupt enable mask.
// Contract
// (R1) Every endpoint has its own receive and transmit interrupt enable bit.
// (R2) A cleared global enable in the mode register suppresses every interrupt.
// (R3) ACK or NAK handshakes raise endpoint interrupts, filtered by a debug mode field.
// (R4) Data IN handshakes use transmit enables and the data IN mode field.
// (R5) Data OUT handshakes use receive enables and the data OUT mode field.
// (R6) All control endpoint handshakes use the control mode field.
// (R7) A USB bus reset clears every enable bit except the bus reset enable.
// (R8) The enable register is a read/write word at 14h, resetting to zero.
// (R9) Data endpoint n transmit enable sits at bit 2n+11, receive at 2n+10.
// (R10) Bit 11 enables control IN, bit 10 enables control OUT interrupts.
// (R11) Bit 8 enables an interrupt on set-up data reception.
// (R12) Bit 7 enables an interrupt on a VBUS polarity change.
// (R13) Bit 6 enables an interrupt on a DMA status change.
// (R14) Bit 5 enables an interrupt on a high-speed status change.
// (R15) Bit 4 enables resume and bit 3 enables suspend interrupts.
// (R16) Bit 2 enables pseudo SOF and bit 1 enables SOF interrupts.
// (R17) Bit 0 enables an interrupt on a detected bus reset.
// (R18) Software keeps bits 31 to 26 and bit 9 at their reset value.
// (R19) Mode 00 all ACK/NAK, 01 ACK only, 1x ACK plus first NAK; the code also passes NYET on OUT except control OUT in 0x.
// (R20) Enabling global with a pending unmasked interrupt asserts the output at once.
// (R21) A source requests only when its event occurs and its enable is one.
package irq_enable_pkg;
  localparam logic [7:0] MODE_OFFSET = 8'h0c;
  localparam logic [7:0] CONF_OFFSET = 8'h10;
  localparam logic [7:0] ENABLE_OFFSET = 8'h14;
  localparam logic [7:0] PENDING_OFFSET = 8'h18;
  localparam int GLOBAL_BIT = 3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CONF_RESET = 8'hfc;
  localparam logic [7:0] CONF_BUS_RESET_MASK = 8'hfc;
  localparam int CTRL_MODE_LSB = 6;
  localparam int IN_MODE_LSB = 4;
  localparam int OUT_MODE_LSB = 2;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_VALID_MASK = 32'h03ff_fdff;
  localparam logic [31:0] ENABLE_BUS_RESET_KEEP = 32'h0000_0001;
  localparam int BUS_RESET_BIT = 0;
  localparam int SETUP_BIT = 8;
  localparam int EP_RX_BASE = 10;
  localparam int EP_TX_BASE = 11;
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_ACK_ONLY = 2'h1;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_NYET} hs_kind_t;
endpackage

// *** verilog/handshake_filter.sv ***
// Debug mode filter that turns endpoint handshakes into interrupt events.
`timescale 1ns/1ps
`default_nettype none
module handshake_filter
  import irq_enable_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Handshake from the serial interface engine.
  input wire logic hs_valid_in,
  input wire logic [2:0] hs_endpoint_in,
  input wire logic hs_in_dir_in,
  input wire logic hs_setup_in,
  input wire logic [1:0] hs_kind_in,
  // Mode fields.
  input wire logic [1:0] ctrl_mode_in,
  input wire logic [1:0] in_mode_in,
  input wire logic [1:0] out_mode_in,
  // Filtered event.
  output logic fire_out,
  output logic [2:0] endpoint_out,
  output logic in_dir_out,
  output logic setup_out
);
  logic [15:0] acked_q;
  logic [3:0] idx;
  logic [1:0] mode;
  logic pass;
  hs_kind_t kind;

  always_comb begin
    kind = hs_kind_t'(hs_kind_in);
    idx = {hs_endpoint_in, hs_in_dir_in & ~hs_setup_in};
    if (hs_endpoint_in == 3'h0) begin
      mode = ctrl_mode_in; // see (R6)
    end else if (hs_in_dir_in) begin
      mode = in_mode_in; // see (R4)
    end else begin
      mode = out_mode_in; // see (R5)
    end
    unique case (kind)
      HS_ACK: pass = 1'b1; // see (R3)
      HS_NYET: pass = (hs_endpoint_in != 3'h0) && !hs_in_dir_in && !mode[1] ? 1'b1 : mode[1] && !hs_in_dir_in;
      HS_NAK: pass = mode[1] ? acked_q[idx] : (mode == MODE_ALL); // see (R19)
      default: pass = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      acked_q <= 16'h0000;
    end else if (hs_valid_in) begin
      if (hs_kind_t'(hs_kind_in) == HS_ACK) begin
        acked_q[idx] <= 1'b1;
      end else if (hs_kind_t'(hs_kind_in) == HS_NAK) begin
        acked_q[idx] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      fire_out <= 1'b0;
      endpoint_out <= 3'h0;
      in_dir_out <= 1'b0;
      setup_out <= 1'b0;
    end else begin
      fire_out <= hs_valid_in && pass; // see (R3)
      endpoint_out <= hs_endpoint_in;
      in_dir_out <= hs_in_dir_in;
      setup_out <= hs_setup_in;
    end
  end
endmodule
`default_nettype wire

// *** verilog/device_interrupt_enable_mask.sv ***
// Interrupt enable mask with Avalon-MM register access and a gated interrupt line.
`timescale 1ns/1ps
`default_nettype none
module device_interrupt_enable_mask
  import irq_enable_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Bus events, one-cycle pulses in enable bit order 7 to 0.
  input wire logic [7:0] bus_event_in,
  input wire logic setup_received_in,
  // Handshake from the serial interface engine.
  input wire logic hs_valid_in,
  input wire logic [2:0] hs_endpoint_in,
  input wire logic hs_in_dir_in,
  input wire logic hs_setup_in,
  input wire logic [1:0] hs_kind_in,
  // Interrupt request.
  output logic irq_out
);
  logic [7:0] mode_q;
  logic [7:0] conf_q;
  logic [31:0] enable_q;
  logic [31:0] pending_q;
  logic [31:0] events;
  logic [31:0] clear_mask;
  logic bus_reset;
  logic wr_take;
  logic rd_take;
  logic filt_fire;
  logic [2:0] filt_endpoint;
  logic filt_in_dir;
  logic filt_setup;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] endpoint_bit(input logic [2:0] ep, input logic in_dir);
    logic [31:0] res;
    res = 32'h0000_0000;
    if (in_dir) begin
      res[EP_TX_BASE + 2 * int'(ep)] = 1'b1; // see (R9) see (R10)
    end else begin
      res[EP_RX_BASE + 2 * int'(ep)] = 1'b1; // see (R9) see (R10)
    end
    return res;
  endfunction

  // The waitrequest flop drops for one cycle after each request is seen.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    end
  end

  assign wr_take = avs_write_in && !avs_waitrequest_out;
  assign rd_take = avs_read_in && avs_waitrequest_out;
  assign bus_reset = bus_event_in[BUS_RESET_BIT];

  // Read data are loaded while the request waits, so they stand with waitrequest low.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (avs_address_in)
        MODE_OFFSET: avs_readdata_out <= {24'h000000, mode_q};
        CONF_OFFSET: avs_readdata_out <= {24'h000000, conf_q};
        ENABLE_OFFSET: avs_readdata_out <= enable_q;
        PENDING_OFFSET: avs_readdata_out <= pending_q;
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Mode register holding the global enable.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_q <= MODE_RESET;
    end else if (wr_take && avs_address_in == MODE_OFFSET && avs_byteenable_in[0]) begin
      mode_q <= avs_writedata_in[7:0];
    end
  end

  // Configuration register holding the handshake mode fields.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      conf_q <= CONF_RESET;
    end else if (bus_reset) begin
      conf_q <= conf_q | CONF_BUS_RESET_MASK;
    end else if (wr_take && avs_address_in == CONF_OFFSET && avs_byteenable_in[0]) begin
      conf_q <= avs_writedata_in[7:0];
    end
  end

  // Enable register; unused bits always hold zero.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      enable_q <= ENABLE_RESET; // see (R8)
    end else if (bus_reset) begin
      enable_q <= enable_q & ENABLE_BUS_RESET_KEEP; // see (R7)
    end else if (wr_take && avs_address_in == ENABLE_OFFSET) begin
      enable_q <= merge_bytes(enable_q, avs_writedata_in, avs_byteenable_in) & ENABLE_VALID_MASK; // see (R8)
    end
  end

  handshake_filter u_filter (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .hs_valid_in(hs_valid_in),
    .hs_endpoint_in(hs_endpoint_in),
    .hs_in_dir_in(hs_in_dir_in),
    .hs_setup_in(hs_setup_in),
    .hs_kind_in(hs_kind_in),
    .ctrl_mode_in(conf_q[CTRL_MODE_LSB +: 2]),
    .in_mode_in(conf_q[IN_MODE_LSB +: 2]),
    .out_mode_in(conf_q[OUT_MODE_LSB +: 2]),
    .fire_out(filt_fire),
    .endpoint_out(filt_endpoint),
    .in_dir_out(filt_in_dir),
    .setup_out(filt_setup)
  );

  // Source events: bus events 7 to 0, set-up at 8, endpoints at 10 to 25.
  always_comb begin
    events = {24'h000000, bus_event_in}; // see (R12) see (R13) see (R14) see (R15) see (R16) see (R17)
    events[SETUP_BIT] = setup_received_in; // see (R11)
    if (filt_fire) begin
      if (filt_setup && filt_endpoint == 3'h0) begin
        events[SETUP_BIT] = 1'b1; // see (R6)
      end else begin
        events = events | endpoint_bit(filt_endpoint, filt_in_dir); // see (R1) see (R4) see (R5)
      end
    end
    clear_mask = 32'h0000_0000;
    if (wr_take && avs_address_in == PENDING_OFFSET) begin
      clear_mask = merge_bytes(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
    end
  end

  // Pending flags set only for enabled sources; a new event wins over a clear.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pending_q <= 32'h0000_0000;
    end else begin
      pending_q <= (pending_q & ~clear_mask) | (events & enable_q); // see (R21)
    end
  end

  // Interrupt line gated by the global enable.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= mode_q[GLOBAL_BIT] && |(pending_q & enable_q); // see (R2) see (R20)
    end
  end

  a_bus_wait_ack:
    assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("Request not answered after one wait cycle.");

  a_global_gate: // see (R2)
    assert property (!mode_q[GLOBAL_BIT] |=> !irq_out)
    else $error("Interrupt raised while global enable is off.");

  a_immediate_irq: // see (R20)
    assert property (mode_q[GLOBAL_BIT] && (pending_q & enable_q) != 32'h0 |=> irq_out)
    else $error("Pending unmasked interrupt did not raise the line.");

  a_bus_reset_clear: // see (R7)
    assert property (bus_reset |=> (enable_q & ~ENABLE_BUS_RESET_KEEP) == 32'h0
                     && enable_q[BUS_RESET_BIT] == $past(enable_q[BUS_RESET_BIT]))
    else $error("Bus reset did not clear enables correctly.");

  a_reserved_zero: // see (R8)
    assert property ((enable_q & ~ENABLE_VALID_MASK) == 32'h0)
    else $error("Reserved enable bit is set.");

  a_write_enable: // see (R8)
    assert property (wr_take && avs_address_in == ENABLE_OFFSET && avs_byteenable_in == 4'hf && !bus_reset
                     |=> enable_q == ($past(avs_writedata_in) & ENABLE_VALID_MASK))
    else $error("Enable register write not stored.");

  a_no_disabled_set: // see (R21)
    assert property (((pending_q & ~$past(pending_q)) & ~$past(enable_q)) == 32'h0)
    else $error("Pending flag set for a disabled source.");

  a_ack_fires: // see (R3)
    assert property (hs_valid_in && hs_kind_in == 2'h0 |=> filt_fire)
    else $error("ACK handshake produced no event.");

  a_ack_only_nak: // see (R19)
    assert property (hs_valid_in && hs_kind_in == 2'h1 && hs_endpoint_in == 3'h0
                     && conf_q[CTRL_MODE_LSB +: 2] == MODE_ACK_ONLY |=> !filt_fire)
    else $error("NAK fired in ACK-only control mode.");

  a_endpoint_route: // see (R9)
    assert property (filt_fire && !filt_setup && filt_endpoint == 3'h7 && filt_in_dir && enable_q[25]
                     |=> pending_q[25])
    else $error("Endpoint 7 transmit event not latched at bit 25.");

  c_irq_rise:
    cover property ($rose(irq_out));

  c_bus_reset_live:
    cover property (bus_reset && enable_q[BUS_RESET_BIT] && enable_q[1]);

  c_first_nak:
    cover property (hs_valid_in && hs_kind_in == 2'h1 && conf_q[IN_MODE_LSB + 1] ##1 filt_fire);
endmodule
`default_nettype wire

// *** bench/irq_service_model.sv ***
// Model of the microprocessor that services the interrupt line.
`timescale 1ns/1ps
`default_nettype none
module irq_service_model (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Interrupt line and service count.
  input wire logic irq_in,
  output var int serviced_out
);
  logic irq_q;
  // Counts each new interrupt request that the processor would service.
  always_ff @(posedge mclk_in) begin
    irq_q <= reset_in ? 1'b0 : irq_in;
    if (reset_in) begin
      serviced_out <= 0;
    end else if (irq_in && !irq_q) begin
      serviced_out <= serviced_out + 1;
    end
  end
endmodule
`default_nettype wire

// *** bench/device_interrupt_enable_mask_tb.sv ***
// Self-checking testbench for the device interrupt enable mask.
`timescale 1ns/1ps
`default_nettype none
module device_interrupt_enable_mask_tb;
  import irq_enable_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [7:0] bus_event_in = 8'h00;
  logic setup_received_in = 1'b0;
  logic hs_valid_in = 1'b0;
  logic [2:0] hs_endpoint_in = 3'h0;
  logic hs_in_dir_in = 1'b0;
  logic hs_setup_in = 1'b0;
  logic [1:0] hs_kind_in = 2'h0;
  logic irq_out;
  logic [31:0] q;
  logic [31:0] w;
  int n_errors = 0;
  int compares = 0;
  int n_irq;
  device_interrupt_enable_mask dut (.mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .bus_event_in(bus_event_in), .setup_received_in(setup_received_in),
    .hs_valid_in(hs_valid_in), .hs_endpoint_in(hs_endpoint_in), .hs_in_dir_in(hs_in_dir_in),
    .hs_setup_in(hs_setup_in), .hs_kind_in(hs_kind_in), .irq_out(irq_out));
  irq_service_model u_mcu (.mclk_in(mclk_in), .reset_in(reset_in), .irq_in(irq_out), .serviced_out(n_irq));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  // Works out the enable bit that a handshake is gated by.
  function automatic logic [31:0] hs_mask(input int ep, input int dir, input logic su);
    return su ? (32'h1 << SETUP_BIT) : (32'h1 << (2 * ep + EP_RX_BASE + dir));
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon-MM access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int i;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (i == 20) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // Clears pending flags, sets the enables, sends one event and checks the line.
  task automatic trial(input logic [31:0] en, input logic [7:0] ev, input logic su, input logic hv,
                       input int ep, input int dr, input logic hsu, input logic [1:0] k, input logic ex);
    bus(1'b1, PENDING_OFFSET, 32'hffff_ffff, 4'hf);
    bus(1'b1, ENABLE_OFFSET, en, 4'hf);
    @(posedge mclk_in);
    bus_event_in <= ev;
    setup_received_in <= su;
    hs_valid_in <= hv;
    hs_endpoint_in <= 3'(ep);
    hs_in_dir_in <= 1'(dr);
    hs_setup_in <= hsu;
    hs_kind_in <= k;
    @(posedge mclk_in);
    bus_event_in <= 8'h00;
    setup_received_in <= 1'b0;
    hs_valid_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
    chk({31'h0, irq_out}, {31'h0, ex});
  endtask
  initial begin
    void'($urandom(51714));
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    bus(1'b0, ENABLE_OFFSET, 32'h0, 4'hf);
    chk(q, ENABLE_RESET);
    bus(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
    bus(1'b0, 8'h20, 32'h0, 4'hf);
    chk(q, 32'h0);
    repeat (20) begin
      w = $urandom() & ENABLE_VALID_MASK;
      bus(1'b1, ENABLE_OFFSET, w, 4'hf);
      bus(1'b0, ENABLE_OFFSET, 32'h0, 4'hf);
      chk(q, w);
    end
    trial(ENABLE_VALID_MASK, 8'h01, 1'b0, 1'b0, 0, 0, 1'b0, HS_ACK, 1'b0);
    bus(1'b0, ENABLE_OFFSET, 32'h0, 4'hf);
    chk(q, ENABLE_BUS_RESET_KEEP);
    bus(1'b1, MODE_OFFSET, 32'h8, 4'h1);
    for (int b = 0; b < 8; b++) begin
      trial(32'h1 << b, 8'(1 << b), 1'b0, 1'b0, 0, 0, 1'b0, HS_ACK, 1'b1);
      trial(ENABLE_VALID_MASK & ~(32'h1 << b), 8'(1 << b), 1'b0, 1'b0, 0, 0, 1'b0, HS_ACK, 1'b0);
    end
    trial(32'h1 << SETUP_BIT, 8'h00, 1'b1, 1'b0, 0, 0, 1'b0, HS_ACK, 1'b1);
    for (int ep = 0; ep < 8; ep++) begin
      for (int dr = 0; dr < 2; dr++) begin
        trial(hs_mask(ep, dr, 1'b0), 8'h00, 1'b0, 1'b1, ep, dr, 1'b0, HS_ACK, 1'b1);
        trial(~hs_mask(ep, dr, 1'b0) & ENABLE_VALID_MASK & ~32'h1, 8'h00, 1'b0, 1'b1, ep, dr, 1'b0, HS_ACK, 1'b0);
      end
    end
    trial(hs_mask(0, 0, 1'b1), 8'h00, 1'b0, 1'b1, 0, 0, 1'b1, HS_ACK, 1'b1);
    bus(1'b1, CONF_OFFSET, 32'h40, 4'h1);
    trial(hs_mask(0, 1, 1'b0), 8'h00, 1'b0, 1'b1, 0, 1, 1'b0, HS_NAK, 1'b0);
    trial(hs_mask(1, 1, 1'b0), 8'h00, 1'b0, 1'b1, 1, 1, 1'b0, HS_NAK, 1'b1);
    trial(hs_mask(1, 0, 1'b0), 8'h00, 1'b0, 1'b1, 1, 0, 1'b0, HS_NYET, 1'b1);
    bus(1'b1, CONF_OFFSET, 32'hfc, 4'h1);
    trial(hs_mask(2, 0, 1'b0), 8'h00, 1'b0, 1'b1, 2, 0, 1'b0, HS_ACK, 1'b1);
    trial(hs_mask(2, 0, 1'b0), 8'h00, 1'b0, 1'b1, 2, 0, 1'b0, HS_NAK, 1'b1);
    trial(hs_mask(2, 0, 1'b0), 8'h00, 1'b0, 1'b1, 2, 0, 1'b0, HS_NAK, 1'b0);
    bus(1'b1, MODE_OFFSET, 32'h0, 4'h1);
    trial(32'h2, 8'h02, 1'b0, 1'b0, 0, 0, 1'b0, HS_ACK, 1'b0);
    bus(1'b1, MODE_OFFSET, 32'h8, 4'h1);
    repeat (2) @(posedge mclk_in);
    #1;
    chk({31'h0, irq_out}, 32'h1);
    chk({31'h0, n_irq > 0}, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
